/* File: cpu_model.sv */
// CPU-side model issuing two-state accesses
`default_nettype none
module cpu_model (
  input wire logic clk_i,
  output logic [23:0] a_o,
  output logic req_o, wr_o, wd_o,
  output logic [15:0] d_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {a_o, req_o, wr_o, wd_o, d_o} = '0;
  task acc(input [23:0] a, input w, wd, input [15:0] d);
    @(posedge clk_i);
    {a_o, req_o, wr_o, wd_o, d_o} <= {a[23:1], a[0] & ~wd, 1'b1, w, wd, d};
    @(posedge clk_i);
    // Idle address and data lines carry inverted junk so stale values cannot pass; wr_o and wd_o keep their values
    {a_o, req_o, d_o} <= {~a, 1'b0, ~d};
  endtask
endmodule // cpu_model
`default_nettype wire

/* File: onchip_ram_decode.v */
// On-chip RAM with window decode and system control register
//
// The implementer's own choice: strobed register access.
`include "ram_decode_map.vh"
`default_nettype none
// Contract
// [R1] Static RAM of 512 bytes, readable and writable by the CPU.
// [R2] RAM connects to the CPU over a 16-bit data path.
// [R3] Window FFD10-FFF0F in modes 1/2, FFFD10-FFFF0F in modes 3/4.
// [R4] Enable 1: window goes to RAM; enable 0: goes external.
// [R5] Enable is bit 0 of system control, 0 off, 1 on, resets 1.
// [R6] Enable reinitialised by external reset; software standby keeps it.
// [R7] Byte access takes two states on the upper 8 data lines.
// [R8] Even-address word access takes two states on all 16 lines.
// [R9] System control register is 8 bits, readable and writable.
// [R10] Software clears enable before entering hardware standby.
// [R11] CPU issues word accesses only at even addresses.
module onchip_ram_decode #(
  parameter RAM_BYTES = `RAM_BYTES
) (
  // Clock and reset
  input wire sys_clk_i,
  input wire srst_i,
  // Operating mode: 0 selects modes 1/2, 1 selects modes 3/4
  input wire mode_wide_i,
  // Software standby indication (no effect on enable)
  input wire soft_standby_i,
  // CPU memory access, first state
  input wire [23:0] cpu_addr_i,
  input wire cpu_req_i,
  input wire cpu_wr_i,
  input wire cpu_word_i,
  input wire [15:0] cpu_wdata_i,
  // CPU memory answer, second state
  output reg cpu_done_o,
  output reg [15:0] cpu_rdata_o,
  output reg ext_req_o,
  // Register port
  input wire [15:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  // Enable state
  output reg ram_enable_bit_o
);
  localparam AW = 8;
  localparam WORDS = RAM_BYTES / 2;

  reg [7:0] system_control_register;
  reg [7:0] next_sysctl;
  reg [7:0] next_reg_rdata;
  reg next_enable;
  reg [AW-1:0] ram_waddr;
  reg ram_wr_hi;
  reg ram_wr_lo;
  reg [15:0] ram_wdata;
  reg [15:0] next_rdata;
  reg next_done;
  reg next_ext;
  wire [15:0] ram_rdata;
  wire hit;
  wire ram_on;
  wire ram_sel;
  wire [23:0] offs;
  wire sysctl_wr;
  wire sysctl_rd;

  // Window test per operating mode
  // Modes 1/2 decode 20 address bits, so the top nibble must be zero
  function in_window;
    input [23:0] a;
    input wide;
    begin
      if (wide) begin
        in_window = (a >= `RAM_WIN_LO_M34) && (a <= `RAM_WIN_HI_M34); // [R3]
      end else begin
        in_window = (a[23:20] == 4'h0) &&
          (a[19:0] >= `RAM_WIN_LO_M12) && (a[19:0] <= `RAM_WIN_HI_M12); // [R3]
      end
    end
  endfunction

  // Byte offset into the array from the base of the active window
  function [23:0] window_offset;
    input [23:0] a;
    input wide;
    begin
      if (wide) begin
        window_offset = a - `RAM_WIN_LO_M34;
      end else begin
        window_offset = a - {4'h0, `RAM_WIN_LO_M12};
      end
    end
  endfunction

  // Register port decode, shared by the write and read paths
  function reg_hit;
    input [15:0] a;
    input strobe;
    begin
      reg_hit = strobe && (a == `SYSCTL_OFFSET);
    end
  endfunction

  assign hit = in_window(cpu_addr_i, mode_wide_i);
  assign offs = window_offset(cpu_addr_i, mode_wide_i);
  assign ram_on = system_control_register[`RAM_EN_POS]; // [R5]
  assign ram_sel = cpu_req_i && hit && ram_on; // [R4]
  assign sysctl_wr = reg_hit(reg_addr_i, reg_wr_i);
  assign sysctl_rd = reg_hit(reg_addr_i, reg_rd_i);

  ram_array #(
    .WORDS(WORDS),
    .AW(AW)
  ) u_ram (
    .sys_clk_i(sys_clk_i),
    .word_addr_i(ram_waddr),
    .wr_hi_i(ram_wr_hi),
    .wr_lo_i(ram_wr_lo),
    .wdata_i(ram_wdata),
    .rdata_o(ram_rdata)
  ); // [R1] [R2]

  // State 1 presents the access; the write lands on the closing edge
  // Odd word addresses fall back to the even word below them
  always @* begin
    ram_waddr = offs[AW:1];
    ram_wr_hi = 1'b0;
    ram_wr_lo = 1'b0;
    ram_wdata = cpu_wdata_i;
    if (ram_sel && cpu_wr_i) begin // [R4]
      if (cpu_word_i) begin
        ram_wr_hi = 1'b1; // [R8]
        ram_wr_lo = 1'b1;
      end else begin
        // Byte data rides the upper lines; odd bytes land in the low lane
        ram_wr_hi = ~offs[0]; // [R7]
        ram_wr_lo = offs[0];
        ram_wdata = {cpu_wdata_i[15:8], cpu_wdata_i[15:8]};
      end
    end
  end

  // State 2 answer; read data holds until the next RAM read
  always @* begin
    next_done = ram_sel; // [R7] [R8]
    // Disabled or outside window: pass to external space
    next_ext = cpu_req_i && !(hit && ram_on); // [R4]
    next_rdata = cpu_rdata_o;
    if (ram_sel && !cpu_wr_i) begin
      if (cpu_word_i) begin
        next_rdata = ram_rdata; // [R8]
      end else if (offs[0]) begin
        next_rdata = {ram_rdata[7:0], 8'h00}; // [R7]
      end else begin
        next_rdata = {ram_rdata[15:8], 8'h00}; // [R7]
      end
    end
  end

  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      cpu_done_o <= 1'b0;
      cpu_rdata_o <= 16'h0000;
      ext_req_o <= 1'b0;
    end else begin
      cpu_done_o <= next_done;
      cpu_rdata_o <= next_rdata;
      ext_req_o <= next_ext;
    end
  end

  // Only the external reset reinitialises the register; standby leaves it
  // The standby input is deliberately not read here
  always @* begin
    next_sysctl = system_control_register;
    next_enable = ram_enable_bit_o;
    next_reg_rdata = 8'h00;
    if (sysctl_wr) begin
      next_sysctl = reg_wdata_i; // [R9] [R5]
      next_enable = reg_wdata_i[`RAM_EN_POS];
    end
    if (sysctl_rd) begin
      next_reg_rdata = system_control_register; // [R9]
    end
  end

  // The enable output mirrors bit 0 from its own flop
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      system_control_register <= `SYSCTL_RESET; // [R5] [R6]
      reg_rdata_o <= 8'h00;
      ram_enable_bit_o <= `RAM_EN_RESET; // [R6]
    end else begin
      system_control_register <= next_sysctl;
      reg_rdata_o <= next_reg_rdata;
      ram_enable_bit_o <= next_enable;
    end
  end
endmodule // onchip_ram_decode
`default_nettype wire

/* File: onchip_ram_decode_test.sv */
// Bench for the RAM decode block
`default_nettype none
`define CK(g,e) begin samples_checked++; if ((g) !== (e)) begin \
  fail_count++; $display("BAD %0t mismatch", $time); end end
module onchip_ram_decode_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 0, srst_i = 1, mode_wide_i = 0, soft_standby_i = 0;
  logic reg_wr_i = 0, reg_rd_i = 0, cpu_req_i, cpu_wr_i, cpu_word_i;
  logic cpu_done_o, ext_req_o, ram_enable_bit_o;
  logic [23:0] cpu_addr_i;
  logic [15:0] reg_addr_i = 0, cpu_wdata_i, cpu_rdata_o;
  logic [7:0] reg_wdata_i = 0, reg_rdata_o;
  int fail_count = 0, samples_checked = 0;
  always #25 sys_clk_i = ~sys_clk_i;
  onchip_ram_decode u_onchip_ram_decode (.*);
  cpu_model u_cpu_model (.clk_i(sys_clk_i), .a_o(cpu_addr_i),
    .req_o(cpu_req_i), .wr_o(cpu_wr_i), .wd_o(cpu_word_i), .d_o(cpu_wdata_i));
  task wr(input [15:0] a, input [7:0] d);
    @(posedge sys_clk_i);
    {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
    @(posedge sys_clk_i);
    reg_wr_i <= 0;
  endtask
  task rd(input [15:0] a, input [7:0] e);
    @(posedge sys_clk_i);
    {reg_addr_i, reg_rd_i} <= {a, 1'b1};
    @(posedge sys_clk_i);
    reg_rd_i <= 0;
    #1 `CK(reg_rdata_o, e)
  endtask
  task m(input [23:0] a, input w, wd, hit, input [15:0] d);
    u_cpu_model.acc(a, w, wd, d);
    #1 `CK({cpu_done_o, ext_req_o}, {hit, !hit})
  endtask
  task regs;
    `CK(ram_enable_bit_o, 1'b1)
    rd(16'hfff2, 8'h0b);
    @(posedge sys_clk_i);
    soft_standby_i <= 1;
    wr(16'hfff2, 8'ha4);
    wr(16'hfff0, 8'hff);
    rd(16'hfff2, 8'ha4);
    rd(16'hfff0, 8'h00);
    `CK(ram_enable_bit_o, 1'b0)
  endtask
  task ram;
    @(posedge sys_clk_i);
    soft_standby_i <= 0;
    wr(16'hfff2, 8'h01);
    m(24'h0ffd10, 1, 1, 1, 16'hbeef);
    m(24'h0ffd11, 1, 0, 1, 16'h5a00);
    m(24'h0ffd10, 0, 1, 1, 16'h0);
    `CK(cpu_rdata_o, 16'hbe5a)
    m(24'h0ffd11, 0, 0, 1, 16'h0);
    `CK(cpu_rdata_o, 16'h5a00)
    m(24'h0fff0f, 1, 0, 1, 16'hc300);
    m(24'h0ffd0f, 0, 0, 0, 16'h0);
    @(posedge sys_clk_i);
    mode_wide_i <= 1;
    m(24'hffff0f, 0, 0, 1, 16'h0);
    `CK(cpu_rdata_o, 16'hc300)
    m(24'h0ffd10, 0, 0, 0, 16'h0);
    wr(16'hfff2, 8'h00);
    m(24'hfffd10, 0, 0, 0, 16'h0);
  endtask
  task rst;
    @(posedge sys_clk_i);
    srst_i <= 1;
    repeat (2) @(posedge sys_clk_i);
    srst_i <= 0;
    #1 `CK(ram_enable_bit_o, 1'b1)
    rd(16'hfff2, 8'h0b);
    m(24'hfffd10, 0, 0, 1, 16'h0);
    `CK(cpu_rdata_o, 16'hbe00)
  endtask
  task stop_test;
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge sys_clk_i);
    srst_i <= 0;
    #1 regs;
    ram;
    rst;
    stop_test;
  end
endmodule // onchip_ram_decode_test
`default_nettype wire

/* File: ram_array.v */
// Byte-laned 16-bit static RAM array
`default_nettype none
module ram_array #(
  parameter WORDS = 256,
  parameter AW = 8
) (
  input wire sys_clk_i,
  input wire [AW-1:0] word_addr_i,
  input wire wr_hi_i,
  input wire wr_lo_i,
  input wire [15:0] wdata_i,
  output reg [15:0] rdata_o
);
  reg [7:0] mem_hi [0:WORDS-1];
  reg [7:0] mem_lo [0:WORDS-1];

  always @(posedge sys_clk_i) begin
    if (wr_hi_i) begin
      mem_hi[word_addr_i] <= wdata_i[15:8];
    end
    if (wr_lo_i) begin
      mem_lo[word_addr_i] <= wdata_i[7:0];
    end
  end

  // Read is combinational so the caller can register it in state 2
  always @* begin
    rdata_o = {mem_hi[word_addr_i], mem_lo[word_addr_i]};
  end
endmodule // ram_array
`default_nettype wire

/* File: ram_decode_checker.sv */
// Port assertions for the RAM decode block
`default_nettype none
module ram_decode_checker (
  input wire logic sys_clk_i, srst_i, mode_wide_i, cpu_req_i, cpu_wr_i,
  input wire logic cpu_word_i, reg_wr_i, reg_rd_i, cpu_done_o, ext_req_o,
  input wire logic ram_enable_bit_o,
  input wire logic [23:0] cpu_addr_i,
  input wire logic [15:0] reg_addr_i, cpu_rdata_o,
  input wire logic [7:0] reg_wdata_i, reg_rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  wire [23:0] a = cpu_addr_i;
  wire hit = cpu_req_i && ram_enable_bit_o && (mode_wide_i ?
    a >= 24'hfffd10 && a <= 24'hffff0f : a >= 24'hffd10 && a <= 24'hfff0f);
  wire sw = reg_wr_i && reg_addr_i == 16'hfff2;
  wire sr = reg_rd_i && reg_addr_i == 16'hfff2;
  ram_hit_a: assert property (hit |=> cpu_done_o)
    else $error("hit");
  ext_miss_a: assert property (cpu_req_i && !hit |=> ext_req_o)
    else $error("miss");
  idle_bus_a: assert property (!cpu_req_i |=> !(cpu_done_o | ext_req_o))
    else $error("idle");
  low_lane_a: assert property (hit && !cpu_wr_i && !cpu_word_i |=>
    cpu_rdata_o[7:0] == 8'h00) else $error("lane");
  en_write_a: assert property (sw |=>
    ram_enable_bit_o == $past(reg_wdata_i[0])) else $error("write");
  en_hold_a: assert property (!sw |=> $stable(ram_enable_bit_o))
    else $error("hold");
  reg_read_a: assert property (sr |=>
    reg_rdata_o[0] == $past(ram_enable_bit_o)) else $error("read");
  read_zero_a: assert property (!sr |=> reg_rdata_o == 8'h00)
    else $error("zero");
endmodule // ram_decode_checker
bind onchip_ram_decode ram_decode_checker u_ram_decode_checker (.*);
`default_nettype wire

/* File: ram_decode_map.vh */
// Address map, field positions and reset values of the on-chip RAM block
`ifndef RAM_DECODE_MAP_VH
`define RAM_DECODE_MAP_VH
`define RAM_BYTES 512
`define RAM_WIN_LO_M12 20'hffd10
`define RAM_WIN_HI_M12 20'hfff0f
`define RAM_WIN_LO_M34 24'hfffd10
`define RAM_WIN_HI_M34 24'hffff0f
`define SYSCTL_OFFSET 16'hfff2
`define SYSCTL_RESET 8'h0b
`define RAM_EN_POS 0
`define RAM_EN_RESET 1'b1
`endif
